// *** logic/disk_stats_pkg.sv ***
package disk_stats_pkg;
   // Command codes: class in the top three bits, opcode below
   localparam logic [7:0] OPC_READ_LONG  = 8'he5;
   localparam logic [7:0] OPC_WRITE_LONG = 8'he6;
   localparam logic [7:0] OPC_STATS      = 8'he7;
   localparam logic [7:0] OPC_DRIVE_DIAG = 8'he3;

   // Control byte bits
   localparam int unsigned CTL_RETRY_DIS  = 7;
   localparam int unsigned CTL_REREAD_DIS = 6;
   localparam int unsigned CTL_FILL_BUF   = 5;

   localparam logic [2:0]  RETRY_RELOAD   = 3'h4;
   localparam logic [4:0]  BURST_MAX      = 5'h0b;
   localparam logic [7:0]  ERR_DEFECTIVE  = 8'h19;
   localparam logic [7:0]  ERR_NONE       = 8'h00;
   localparam logic [7:0]  FILL_DEFAULT   = 8'h6c;
   localparam logic [15:0] CNT_MAX        = 16'hffff;
   localparam logic [3:0]  STAT_BYTES     = 4'h8;
   localparam logic [9:0]  LEN_256        = 10'h100;
   localparam logic [9:0]  LEN_512        = 10'h200;
   localparam logic [9:0]  CHECK_LEN      = 10'h004;

   // Register indices on the plain register port
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_STATUS   = 4'h1;
   localparam logic [3:0] REG_CNT_BASE = 4'h2;
   localparam logic [3:0] REG_SENSE_HI = 4'h6;
   localparam logic [3:0] REG_SENSE_LO = 4'h7;
   localparam logic [15:0] CTRL_RESET  = 16'h0000;

   // Counter slots, in the order they are returned
   localparam int unsigned CNT_UNREC = 0;
   localparam int unsigned CNT_REC   = 1;
   localparam int unsigned CNT_SOFT  = 2;
   localparam int unsigned CNT_CORR  = 3;

   // Sector field lengths in bytes
   localparam logic [9:0] LEN_GAP_LEAD  = 10'h009;
   localparam logic [9:0] LEN_MARK      = 10'h004;
   localparam logic [9:0] LEN_ONE       = 10'h001;
   localparam logic [9:0] LEN_ZERO2     = 10'h002;
   localparam logic [9:0] LEN_GAP_ID    = 10'h010;
   localparam logic [9:0] LEN_IRG_256   = 10'h00e;
   localparam logic [9:0] LEN_IRG_512   = 10'h022;

   typedef enum logic [1:0] {RES_OK, RES_CHECK, RES_MEDIA, RES_DEFECT} result_kind_t;

   typedef enum logic [4:0] {
      F_LEAD, F_MARK, F_MARK_GAP, F_ID_SYNC, F_ID_ZERO2, F_COMPARE, F_CYL_HI, F_CYL_LO,
      F_HEAD, F_SECTOR, F_FLAG, F_ID_ZERO, F_ID_CHECK, F_ID_GAP, F_DATA_SYNC,
      F_DATA_ZERO2, F_DATA, F_DATA_CHECK, F_IRG
   } field_t;

   typedef struct packed {
      logic         valid;
      result_kind_t kind;
      logic [4:0]   burst;
   } rd_result_t;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } host_byte_t;

   typedef struct packed {
      logic [7:0] cylinder_high;
      logic [7:0] cylinder_low;
      logic [7:0] head;
      logic [7:0] sector;
      logic [7:0] flag;
   } id_t;

   typedef struct packed {
      logic       valid;
      field_t     field;
      logic [7:0] data;
   } fmt_byte_t;
endpackage

// *** logic/disk_retry_stats.sv ***
// Notes on behaviour
// - Long write records host-supplied check bytes
// - Long transfers carry four extra check bytes
// - Statistics command returns eight bytes
// - Four counters, high byte first, fixed order
// - Count errors surviving all retries
// - Count errors cured by a retry
// - Check error rereads once; clean reread counts soft
// - Reread fails but correction works: count corrected
// - Uncorrectable errors retry only if allowed
// - Counters clear on statistics command and reset
// - Counters saturate at all ones
// - Bursts over eleven bits are uncorrectable
// - Short sector field layout
// - Long sector: extra gap, bigger data, longer tail
// - Reread unless reread-disable bit set
// - Reread does not consume a retry
// - Retry count reloads to four per good sector
// - Defective track read ends with code 19
// - Drive test recalibrates, checks IDs, never writes
// - Format error keeps defective track address
// - Format fills data from buffer when asked
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module disk_retry_stats #(
   parameter logic [7:0] ERR_UNCORR   = 8'h11,
   parameter logic [7:0] ERR_MEDIA    = 8'h03,
   parameter logic [7:0] MARK_BYTE    = 8'ha1,
   parameter logic [7:0] SYNC_BYTE    = 8'h01,
   parameter logic [7:0] COMPARE_BYTE = 8'hfe
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [3:0]               reg_addr,
   input  wire logic [15:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic [15:0]                   reg_rdata,
   input  wire logic                     cmd_valid,
   input  wire logic [7:0]               cmd_opcode,
   input  wire logic [7:0]               cmd_control,
   input  wire disk_stats_pkg::rd_result_t read_res,
   output logic                          reread_req,
   output logic                          retry_req,
   output logic                          correct_req,
   output logic                          sector_ok,
   output logic                          sector_fail,
   output logic [7:0]                    error_code,
   output logic [9:0]                    xfer_len,
   output logic                          check_from_host,
   output logic                          check_to_host,
   output disk_stats_pkg::host_byte_t    stat_out,
   input  wire logic                     stat_ready,
   input  wire logic                     fmt_start,
   input  wire logic [7:0]               fmt_control,
   input  wire disk_stats_pkg::id_t      fmt_id,
   input  wire logic [7:0]               check_byte,
   input  wire logic [7:0]               buf_byte,
   output disk_stats_pkg::fmt_byte_t     fmt_out,
   output logic                          fmt_done,
   input  wire logic                     fmt_err_valid,
   input  wire logic [23:0]              fmt_err_track,
   output logic [23:0]                   sense_track,
   input  wire logic                     diag_id_valid,
   input  wire logic                     diag_id_ok,
   input  wire logic                     diag_last_track,
   output logic                          diag_recal,
   output logic                          diag_step,
   output logic                          diag_active,
   output logic                          write_inhibit
);
   import disk_stats_pkg::*;

   typedef enum logic [1:0] {ST_FIRST, ST_REREAD, ST_RETRY} rstate_t;

   rstate_t     state_reg, state_next;
   logic [7:0]  ctl_reg;
   logic [2:0]  retry_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] cnt_reg [4];
   logic [3:0]  inc;
   logic        clr;
   logic        d_reread, d_retry, d_corr, d_ok, d_fail;
   logic [7:0]  d_code;
   logic        retry_ok;
   logic        long_wr_reg, long_rd_reg;
   logic [63:0] snap_reg;
   logic [3:0]  stat_cnt_reg;

   ////////////////////////////////////////////////////////////////////////
   // Command latch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_reg     <= 8'h00;
         long_wr_reg <= 1'b0;
         long_rd_reg <= 1'b0;
      end
      else if (cmd_valid)
      begin
         ctl_reg     <= cmd_control;
         long_wr_reg <= (cmd_opcode == OPC_WRITE_LONG);
         long_rd_reg <= (cmd_opcode == OPC_READ_LONG);
      end
   end

   assign check_from_host = long_wr_reg;
   assign check_to_host   = long_rd_reg;
   assign xfer_len = (ctrl_reg[0] ? LEN_512 : LEN_256)
                     + ((long_wr_reg || long_rd_reg) ? CHECK_LEN : 10'h000);

   ////////////////////////////////////////////////////////////////////////
   // Error-handling policy
   assign retry_ok = !ctl_reg[CTL_RETRY_DIS] && (retry_reg != 3'h0);

   always_comb
   begin
      state_next = state_reg;
      d_reread = 1'b0;
      d_retry  = 1'b0;
      d_corr   = 1'b0;
      d_ok     = 1'b0;
      d_fail   = 1'b0;
      d_code   = ERR_NONE;
      inc      = 4'h0;
      if (read_res.valid)
      begin
         unique case (read_res.kind)
            RES_OK:
            begin
               d_ok = 1'b1;
               state_next = ST_FIRST;
               if (state_reg == ST_REREAD)
                  inc[CNT_SOFT] = 1'b1;
               else if (state_reg == ST_RETRY)
                  inc[CNT_REC] = 1'b1;
            end
            RES_CHECK:
            begin
               if (state_reg == ST_FIRST && !ctl_reg[CTL_REREAD_DIS])
               begin
                  d_reread = 1'b1;
                  state_next = ST_REREAD;
               end
               else if (read_res.burst <= BURST_MAX)
               begin
                  d_corr = 1'b1;
                  d_ok = 1'b1;
                  inc[CNT_CORR] = 1'b1;
                  state_next = ST_FIRST;
               end
               else if (retry_ok)
               begin
                  d_retry = 1'b1;
                  state_next = ST_RETRY;
               end
               else
               begin
                  d_fail = 1'b1;
                  d_code = ERR_UNCORR;
                  inc[CNT_UNREC] = 1'b1;
                  state_next = ST_FIRST;
               end
            end
            RES_MEDIA:
            begin
               if (retry_ok)
               begin
                  d_retry = 1'b1;
                  state_next = ST_RETRY;
               end
               else
               begin
                  d_fail = 1'b1;
                  d_code = ERR_MEDIA;
                  inc[CNT_UNREC] = 1'b1;
                  state_next = ST_FIRST;
               end
            end
            RES_DEFECT:
            begin
               d_fail = 1'b1;
               d_code = ERR_DEFECTIVE;
               state_next = ST_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg   <= ST_FIRST;
         retry_reg   <= RETRY_RELOAD;
         reread_req  <= 1'b0;
         retry_req   <= 1'b0;
         correct_req <= 1'b0;
         sector_ok   <= 1'b0;
         sector_fail <= 1'b0;
         error_code  <= ERR_NONE;
      end
      else
      begin
         state_reg   <= cmd_valid ? ST_FIRST : state_next;
         reread_req  <= d_reread;
         retry_req   <= d_retry;
         correct_req <= d_corr;
         sector_ok   <= d_ok;
         sector_fail <= d_fail;
         if (d_fail)
            error_code <= d_code;
         else if (cmd_valid)
            error_code <= ERR_NONE;
         // Reread leaves the budget alone; only real retries spend it
         if (cmd_valid || d_ok)
            retry_reg <= RETRY_RELOAD;
         else if (d_retry)
            retry_reg <= retry_reg - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Statistics counters
   assign clr = cmd_valid && (cmd_opcode == OPC_STATS);

   for (genvar i = 0; i < 4; i++)
   begin : g_cnt
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            cnt_reg[i] <= 16'h0000;
         else if (clr)
            cnt_reg[i] <= 16'h0000;
         else if (inc[i] && cnt_reg[i] != CNT_MAX)
            cnt_reg[i] <= cnt_reg[i] + 16'h0001;
      end
   end

   // Snapshot taken in the clearing cycle keeps the counts held before the clear; an increment in that same cycle is lost
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         snap_reg     <= 64'h0;
         stat_cnt_reg <= 4'h0;
      end
      else if (clr)
      begin
         snap_reg     <= {cnt_reg[CNT_UNREC], cnt_reg[CNT_REC],
                          cnt_reg[CNT_SOFT], cnt_reg[CNT_CORR]};
         stat_cnt_reg <= STAT_BYTES;
      end
      else if (stat_out.valid && stat_ready)
      begin
         snap_reg     <= {snap_reg[55:0], 8'h00};
         stat_cnt_reg <= stat_cnt_reg - 4'h1;
      end
   end

   assign stat_out.valid = (stat_cnt_reg != 4'h0);
   assign stat_out.last  = (stat_cnt_reg == 4'h1);
   assign stat_out.data  = snap_reg[63:56];

   ////////////////////////////////////////////////////////////////////////
   // Sector layout sequencer
   field_t     fld_reg;
   logic [9:0] pos_reg;
   logic       fmt_run_reg;
   logic       fill_buf_reg;
   logic [9:0] fld_len;
   logic [7:0] fld_byte;
   logic       fld_end;
   field_t     fld_next;

   always_comb
   begin
      fld_len = LEN_ONE;
      unique case (fld_reg)
         F_LEAD, F_MARK_GAP:        fld_len = LEN_GAP_LEAD;
         F_MARK, F_ID_CHECK,
         F_DATA_CHECK:              fld_len = LEN_MARK;
         F_ID_ZERO2, F_DATA_ZERO2:  fld_len = LEN_ZERO2;
         F_ID_GAP:                  fld_len = LEN_GAP_ID;
         F_DATA:                    fld_len = ctrl_reg[0] ? LEN_512 : LEN_256;
         F_IRG:                     fld_len = ctrl_reg[0] ? LEN_IRG_512 : LEN_IRG_256;
         default:                   fld_len = LEN_ONE;
      endcase
   end

   always_comb
   begin
      fld_byte = 8'h00;
      unique case (fld_reg)
         F_MARK:                    fld_byte = MARK_BYTE;
         F_ID_SYNC, F_DATA_SYNC:    fld_byte = SYNC_BYTE;
         F_COMPARE:                 fld_byte = COMPARE_BYTE;
         F_CYL_HI:                  fld_byte = fmt_id.cylinder_high;
         F_CYL_LO:                  fld_byte = fmt_id.cylinder_low;
         F_HEAD:                    fld_byte = fmt_id.head;
         F_SECTOR:                  fld_byte = fmt_id.sector;
         F_FLAG:                    fld_byte = fmt_id.flag;
         F_ID_CHECK, F_DATA_CHECK:  fld_byte = check_byte;
         F_DATA:                    fld_byte = fill_buf_reg ? buf_byte : FILL_DEFAULT;
         default:                   fld_byte = 8'h00;
      endcase
   end

   assign fld_end  = (pos_reg == fld_len - 10'h001);
   // The second lead gap exists only on long sectors
   assign fld_next = (fld_reg == F_MARK && !ctrl_reg[0]) ? F_ID_SYNC
                     : field_t'(fld_reg + 5'h01);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fld_reg      <= F_LEAD;
         pos_reg      <= 10'h000;
         fmt_run_reg  <= 1'b0;
         fill_buf_reg <= 1'b0;
      end
      else if (fmt_start && !fmt_run_reg)
      begin
         fld_reg      <= F_LEAD;
         pos_reg      <= 10'h000;
         fmt_run_reg  <= 1'b1;
         fill_buf_reg <= fmt_control[CTL_FILL_BUF];
      end
      else if (fmt_run_reg)
      begin
         if (!fld_end)
            pos_reg <= pos_reg + 10'h001;
         else
         begin
            pos_reg <= 10'h000;
            if (fld_reg == F_IRG)
               fmt_run_reg <= 1'b0;
            else
               fld_reg <= fld_next;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fmt_out  <= '{valid: 1'b0, field: F_LEAD, data: 8'h00};
         fmt_done <= 1'b0;
      end
      else
      begin
         fmt_out  <= '{valid: fmt_run_reg, field: fld_reg, data: fld_byte};
         fmt_done <= fmt_run_reg && fld_end && (fld_reg == F_IRG);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Format error sense and drive diagnostic
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sense_track <= 24'h000000;
      else if (fmt_err_valid)
         sense_track <= fmt_err_track;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_active <= 1'b0;
         diag_recal  <= 1'b0;
         diag_step   <= 1'b0;
      end
      else
      begin
         diag_recal <= cmd_valid && (cmd_opcode == OPC_DRIVE_DIAG);
         diag_step  <= diag_active && diag_id_valid && diag_id_ok && !diag_last_track;
         if (cmd_valid)
            diag_active <= (cmd_opcode == OPC_DRIVE_DIAG);
         else if (diag_id_valid && (!diag_id_ok || diag_last_track))
            diag_active <= 1'b0;
      end
   end

   // Drive test only reads; the media path must not write meanwhile
   assign write_inhibit = diag_active;

   ////////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_reg <= CTRL_RESET;
      else if (reg_wr && reg_addr == REG_CTRL)
         ctrl_reg <= {15'h0000, reg_wdata[0]};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            REG_CTRL:     reg_rdata <= ctrl_reg;
            REG_STATUS:   reg_rdata <= {8'h00, diag_active, fmt_run_reg,
                                        state_reg, 1'b0, retry_reg};
            4'h2, 4'h3,
            4'h4, 4'h5:   reg_rdata <= cnt_reg[2'(reg_addr - REG_CNT_BASE)];
            REG_SENSE_HI: reg_rdata <= {8'h00, sense_track[23:16]};
            REG_SENSE_LO: reg_rdata <= sense_track[15:0];
            default:      reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_check_first;
      read_res.valid && read_res.kind == RES_CHECK && state_reg == ST_FIRST;
   endsequence

   sequence s_stats_cmd;
      cmd_valid && cmd_opcode == OPC_STATS;
   endsequence

   chk_reread_first: assert property (@(posedge clk) disable iff (!rst_n)
      s_check_first and !ctl_reg[CTL_REREAD_DIS] && !cmd_valid |=> reread_req && !retry_req
         && state_reg == ST_REREAD)
      else $error("check error on first read did not reread");

   chk_reread_free: assert property (@(posedge clk) disable iff (!rst_n)
      s_check_first and !cmd_valid && !ctl_reg[CTL_REREAD_DIS] |=> retry_reg == $past(retry_reg))
      else $error("reread spent a retry");

   chk_soft_count: assert property (@(posedge clk) disable iff (!rst_n)
      read_res.valid && read_res.kind == RES_OK && state_reg == ST_REREAD && !clr
         && cnt_reg[CNT_SOFT] != CNT_MAX |=> cnt_reg[CNT_SOFT] == $past(cnt_reg[CNT_SOFT]) + 16'h1)
      else $error("soft counter missed clean reread");

   chk_burst_limit: assert property (@(posedge clk) disable iff (!rst_n)
      read_res.valid && read_res.kind == RES_CHECK && state_reg != ST_FIRST
         && read_res.burst > BURST_MAX |=> !correct_req)
      else $error("long burst was corrected");

   chk_sat_hold: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_reg[CNT_UNREC] == CNT_MAX && !clr |=> cnt_reg[CNT_UNREC] == CNT_MAX)
      else $error("counter left saturation");

   chk_stats_clear: assert property (@(posedge clk) disable iff (!rst_n)
      s_stats_cmd |=> cnt_reg[0] == 16'h0 && cnt_reg[3] == 16'h0 && stat_cnt_reg == STAT_BYTES)
      else $error("statistics command did not clear");

   chk_stats_first: assert property (@(posedge clk) disable iff (!rst_n)
      s_stats_cmd |=> stat_out.valid && stat_out.data == $past(cnt_reg[CNT_UNREC][15:8]))
      else $error("statistics stream not high byte first");

   chk_retry_reload: assert property (@(posedge clk) disable iff (!rst_n)
      sector_ok |-> retry_reg == RETRY_RELOAD)
      else $error("retry budget not reloaded");

   chk_defect_code: assert property (@(posedge clk) disable iff (!rst_n)
      read_res.valid && read_res.kind == RES_DEFECT |=> sector_fail && error_code == ERR_DEFECTIVE)
      else $error("defective track code wrong");

   chk_long_len: assert property (@(posedge clk) disable iff (!rst_n)
      long_rd_reg && !ctrl_reg[0] |-> xfer_len == 10'd260)
      else $error("long transfer length wrong");

   chk_diag_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
      cmd_valid && cmd_opcode == OPC_DRIVE_DIAG |=> diag_recal && write_inhibit)
      else $error("drive test without recalibrate or inhibit");
endmodule // disk_retry_stats

// *** test/drive_model.sv ***
`timescale 1ns/1ps
module drive_model
   import disk_stats_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          go,
   input  wire disk_stats_pkg::result_kind_t  kind,
   input  wire logic [4:0]                    burst,
   output disk_stats_pkg::rd_result_t         read_res
);
   // One result per clock that go is high, one clock later; valid stays high as long as go does
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         read_res <= '0;
      else
         read_res <= '{valid: go, kind: kind, burst: burst};
   end
endmodule // drive_model

// *** test/disk_retry_stats_test.sv ***
`timescale 1ns/1ps
module disk_retry_stats_test;
   import disk_stats_pkg::*;
   localparam logic [7:0] E_UNC = 8'h11;
   localparam logic [7:0] E_MED = 8'h03;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0, go = 1'b0;
   logic stat_ready = 1'b0, fmt_start = 1'b0, fmt_err = 1'b0, id_vld = 1'b0, id_ok = 1'b0;
   logic id_last = 1'b0, reread_req, retry_req, correct_req, sector_ok, sector_fail, fmt_done;
   logic             rdy_h, rdy_t, diag_recal, diag_step, diag_active, write_inhibit;
   logic [3:0]       reg_addr = '0;
   logic [15:0]      reg_wdata = '0, reg_rdata;
   logic [7:0]       op = '0, ctl = '0, fctl = 8'h20, error_code;
   logic [9:0]       xfer_len;
   logic [23:0]      err_trk = 24'h0a0b0c, sense_track;
   logic [4:0]       burst = '0, pl;
   logic [63:0]      stats = {16'h3, 16'h1, 16'h1, 16'h2};
   result_kind_t     kind = RES_OK;
   rd_result_t       read_res;
   host_byte_t       stat_out;
   fmt_byte_t        fmt_out;
   int               err_total = 0, n_tests = 0, cycles = 0, i, j, nb, nd;
   assign pl = {reread_req, retry_req, correct_req, sector_ok, sector_fail};
   always #2.5 clk = ~clk;
   drive_model drv (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind), .burst(burst),
      .read_res(read_res));
   disk_retry_stats #(.ERR_UNCORR(E_UNC), .ERR_MEDIA(E_MED)) dut (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_opcode(op), .cmd_control(ctl),
      .read_res(read_res), .reread_req(reread_req), .retry_req(retry_req),
      .correct_req(correct_req), .sector_ok(sector_ok), .sector_fail(sector_fail),
      .error_code(error_code), .xfer_len(xfer_len), .check_from_host(rdy_h),
      .check_to_host(rdy_t), .stat_out(stat_out), .stat_ready(stat_ready),
      .fmt_start(fmt_start), .fmt_control(fctl), .fmt_id(40'h0102030405),
      .check_byte(8'h5a), .buf_byte(8'h3c), .fmt_out(fmt_out), .fmt_done(fmt_done),
      .fmt_err_valid(fmt_err), .fmt_err_track(err_trk), .sense_track(sense_track),
      .diag_id_valid(id_vld), .diag_id_ok(id_ok), .diag_last_track(id_last),
      .diag_recal(diag_recal), .diag_step(diag_step), .diag_active(diag_active),
      .write_inhibit(write_inhibit));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic cmd(input logic [7:0] o, input logic [7:0] c);
      @(posedge clk);
      cmd_valid <= 1'b1;
      op <= o;
      ctl <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
   endtask
   // Result goes through the drive model, so pulses land three edges on
   task automatic att(input result_kind_t k, input logic [4:0] b, input logic [4:0] exp);
      @(posedge clk);
      go <= 1'b1;
      kind <= k;
      burst <= b;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1 chk(16'(pl), 16'(exp));
   endtask
   task automatic burn(input result_kind_t k, input logic [4:0] b);
      for (j = 0; j < 5; j++)
         att(k, b, (j < 4) ? 5'h08 : 5'h01);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic fmt(input int eb, input int ed);
      @(posedge clk);
      fmt_start <= 1'b1;
      @(posedge clk);
      fmt_start <= 1'b0;
      nb = 0;
      nd = 0;
      for (j = 0; j < 800; j++)
      begin
         @(posedge clk);
         #1;
         nb += fmt_out.valid;
         nd += (fmt_out.valid && fmt_out.field == F_DATA && fmt_out.data === 8'h3c);
         if (fmt_done === 1'b1)
            j = 800;
      end
      chk(16'(nb), 16'(eb));
      chk(16'(nd), 16'(ed));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 2; i < 6; i++) rd(4'(i), 16'h0);
      cmd(OPC_READ_LONG, 8'h00);
      chk(16'(xfer_len), 16'h104);
      att(RES_CHECK, 5'h0, 5'h10);
      att(RES_OK, 5'h0, 5'h02);
      rd(4'h4, 16'h1);
      cmd(OPC_READ_LONG, 8'h00);
      att(RES_CHECK, 5'h0, 5'h10);
      att(RES_CHECK, 5'h0b, 5'h06);
      cmd(OPC_READ_LONG, 8'h80);
      att(RES_CHECK, 5'h0, 5'h10);
      att(RES_CHECK, 5'h0c, 5'h01);
      chk(16'(error_code), 16'(E_UNC));
      cmd(OPC_READ_LONG, 8'h40);
      att(RES_CHECK, 5'h0b, 5'h06);
      rd(4'h5, 16'h2);
      $display("test correction done");
      cmd(OPC_READ_LONG, 8'h00);
      for (i = 0; i < 3; i++) att(RES_MEDIA, 5'h0, 5'h08);
      att(RES_OK, 5'h0, 5'h02);
      burn(RES_MEDIA, 5'h0);
      chk(16'(error_code), 16'(E_MED));
      cmd(OPC_READ_LONG, 8'h00);
      att(RES_CHECK, 5'h0, 5'h10);
      burn(RES_CHECK, 5'h0c);
      cmd(OPC_READ_LONG, 8'h00);
      att(RES_DEFECT, 5'h0, 5'h01);
      chk(16'(error_code), 16'h19);
      rd(4'h2, 16'h3);
      rd(4'h3, 16'h1);
      $display("test retries done");
      cmd(OPC_STATS, 8'h00);
      for (i = 0; i < 8; i++)
      begin
         chk(16'({stat_out.valid, stat_out.last, stat_out.data}),
            16'({1'b1, i == 7, stats[63 - 8 * i -: 8]}));
         @(posedge clk);
         stat_ready <= 1'b1;
         @(posedge clk);
         stat_ready <= 1'b0;
         #1;
      end
      chk(16'(stat_out.valid), 16'h0);
      for (i = 2; i < 6; i++) rd(4'(i), 16'h0);
      $display("test statistics done");
      cmd(OPC_WRITE_LONG, 8'h00);
      chk(16'({rdy_h, rdy_t}), 16'h2);
      wr(REG_CTRL, 16'h1);
      #1 chk(16'(xfer_len), 16'h204);
      fmt(605, 512);
      wr(REG_CTRL, 16'h0);
      rd(REG_CTRL, 16'h0);
      fmt(320, 256);
      cmd(OPC_DRIVE_DIAG, 8'h00);
      chk(16'({diag_recal, write_inhibit}), 16'h3);
      id_vld <= 1'b1;
      id_ok <= 1'b1;
      @(posedge clk);
      id_last <= 1'b1;
      fmt_err <= 1'b1;
      #1 chk(16'({diag_active, diag_step}), 16'h3);
      @(posedge clk);
      id_vld <= 1'b0;
      fmt_err <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(16'({diag_active, diag_step}), 16'h0);
      rd(REG_SENSE_LO, 16'h0b0c);
      rd(REG_SENSE_HI, 16'h000a);
      $display("test format and diagnostic done");
      cmd(OPC_READ_LONG, 8'h00);
      att(RES_CHECK, 5'h0, 5'h10);
      att(RES_OK, 5'h0, 5'h02);
      rd(4'h4, 16'h1);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rd(4'h4, 16'h0);
      $display("test reset done");
      give_verdict();
   end
endmodule // disk_retry_stats_test
